// ===== common/sflash_if.sv
// Serial link between the flash front end and its host controller
`timescale 1ns/1ns
interface sflash_if;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic so_line;
	logic rdy;
	logic rst_pin_n;

	// Pulled up while the device floats its output
	assign so_line = so_oe ? so : 1'b1;

	modport dev  (input sck, cs_n, si, rst_pin_n, output so, so_oe, rdy);
	modport host (output sck, cs_n, si, rst_pin_n, input so_line, rdy);
endinterface

// ===== common/sflash_pkg.sv
// Shared constants, opcodes and helpers for the serial page flash link
package sflash_pkg;
	localparam int           HCLK_NS        = 50;
	localparam int           SCK_PERIOD_NS  = 400;
	localparam int           SCK_HALF_CYC   = SCK_PERIOD_NS / (2 * HCLK_NS);
	localparam int           SAMPLE_CYC     = 2;
	localparam logic [8:0]   PAGE_LAST      = 9'h107;
	localparam int           ADDR_BITS      = 24;
	localparam int           DUMMY_PAGE     = 32;
	localparam int           DUMMY_BUF      = 8;
	localparam int           PAGE_LSB       = 9;
	localparam logic [2:0]   DENSITY_CODE   = 3'h3;
	localparam logic [2:0]   STAT_RSVD      = 3'h0;
	localparam logic [7:0]   OP_PAGE_RD     = 8'h52;
	localparam logic [7:0]   OP_BUF1_RD     = 8'h54;
	localparam logic [7:0]   OP_BUF2_RD     = 8'h56;
	localparam logic [7:0]   OP_BUF1_WR     = 8'h84;
	localparam logic [7:0]   OP_BUF2_WR     = 8'h87;
	localparam logic [7:0]   OP_XFER1       = 8'h53;
	localparam logic [7:0]   OP_XFER2       = 8'h55;
	localparam logic [7:0]   OP_CMP1        = 8'h60;
	localparam logic [7:0]   OP_CMP2        = 8'h61;
	localparam logic [7:0]   OP_PGM_ER1     = 8'h83;
	localparam logic [7:0]   OP_PGM_ER2     = 8'h86;
	localparam logic [7:0]   OP_PGM1        = 8'h88;
	localparam logic [7:0]   OP_PGM2        = 8'h89;
	localparam logic [7:0]   OP_THRU1       = 8'h82;
	localparam logic [7:0]   OP_THRU2       = 8'h85;
	localparam logic [7:0]   OP_REWR1       = 8'h58;
	localparam logic [7:0]   OP_REWR2       = 8'h59;
	localparam logic [7:0]   OP_STATUS      = 8'h57;
	localparam logic [11:0]  REG_CMD        = 12'h000;
	localparam logic [11:0]  REG_STAT       = 12'h004;
	localparam logic [11:0]  REG_CFG        = 12'h008;
	localparam int           CMD_HOLD_BIT   = 8;
	localparam int           CFG_MODE3_BIT  = 0;
	localparam int           CFG_RST_BIT    = 1;

	function automatic logic is_launch(input logic [7:0] op);
		return op inside {OP_XFER1, OP_XFER2, OP_CMP1, OP_CMP2, OP_PGM_ER1, OP_PGM_ER2,
			OP_PGM1, OP_PGM2, OP_THRU1, OP_THRU2, OP_REWR1, OP_REWR2};
	endfunction

	function automatic logic is_read(input logic [7:0] op);
		return op inside {OP_PAGE_RD, OP_BUF1_RD, OP_BUF2_RD, OP_STATUS};
	endfunction

	function automatic logic is_write(input logic [7:0] op);
		return op inside {OP_BUF1_WR, OP_BUF2_WR, OP_THRU1, OP_THRU2};
	endfunction

	function automatic logic is_valid(input logic [7:0] op);
		return is_launch(op) || is_read(op) || is_write(op);
	endfunction
endpackage

// ===== hdl/flash_front_end.sv
// Serial command front end of the page flash device with two page buffers
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
module flash_front_end (
	input  wire logic  hclk,
	input  wire logic  hresetn,
	sflash_if.dev      link,
	input  wire logic  op_done,
	input  wire logic  op_mismatch,
	input  wire logic  [7:0] arr_rdata,
	output logic       op_valid,
	output logic [7:0] op_code,
	output logic [10:0] op_page,
	output logic [8:0] arr_byte
);
	typedef enum logic [1:0] {PH_OP, PH_HDR, PH_DATA, PH_BAD} phase_t;

	typedef struct packed {
		phase_t      phase;
		logic [6:0]  cnt;
		logic [2:0]  bcnt;
		logic [7:0]  ish;
		logic [7:0]  osh;
		logic [7:0]  op;
		logic [23:0] adr;
		logic [8:0]  ptr;
		logic        busy;
		logic        cmp;
		logic        so;
		logic        so_oe;
		logic        rdy;
		logic        op_valid;
		logic [7:0]  op_code;
		logic [10:0] op_page;
	} state_t;

	state_t     r;
	state_t     n;
	logic       sck_q;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_q;
	logic       cs_rise;
	logic       si_q;
	logic       rst_q;
	logic       wr_en;
	logic       wr_b2;
	logic [8:0] wr_adr;
	logic [7:0] wr_dat;
	logic [7:0] buf1 [0:263];
	logic [7:0] buf2 [0:263];

	pin_sync #(.RST_VAL(1'b0)) u_sck (.hclk(hclk), .hresetn(hresetn), .d(link.sck),
		.q(sck_q), .rise(sck_rise), .fall(sck_fall));
	pin_sync u_cs (.hclk(hclk), .hresetn(hresetn), .d(link.cs_n),
		.q(cs_q), .rise(cs_rise), .fall());
	pin_sync u_si (.hclk(hclk), .hresetn(hresetn), .d(link.si),
		.q(si_q), .rise(), .fall());
	pin_sync u_rst (.hclk(hclk), .hresetn(hresetn), .d(link.rst_pin_n),
		.q(rst_q), .rise(), .fall());

	function automatic logic [8:0] next_ptr(input logic [8:0] p);
		return (p == sflash_pkg::PAGE_LAST) ? 9'h000 : p + 9'h001;
	endfunction

	function automatic int hdr_bits(input logic [7:0] op);
		if (op == sflash_pkg::OP_PAGE_RD) begin
			return sflash_pkg::ADDR_BITS + sflash_pkg::DUMMY_PAGE;
		end else if (op == sflash_pkg::OP_BUF1_RD || op == sflash_pkg::OP_BUF2_RD) begin
			return sflash_pkg::ADDR_BITS + sflash_pkg::DUMMY_BUF;
		end
		return sflash_pkg::ADDR_BITS;
	endfunction

	function automatic logic use_buf2(input logic [7:0] op);
		return op inside {sflash_pkg::OP_BUF2_RD, sflash_pkg::OP_BUF2_WR, sflash_pkg::OP_THRU2};
	endfunction

	always_comb begin
		logic [7:0]  ish_n;
		logic [23:0] adr_n;
		logic [7:0]  src;
		ish_n  = {r.ish[6:0], si_q};
		adr_n  = {r.adr[22:0], si_q};
		src    = 8'h00;
		n      = r;
		wr_en  = 1'b0;
		wr_b2  = use_buf2(r.op);
		wr_adr = r.ptr;
		wr_dat = ish_n;
		n.op_valid = 1'b0;
		if (!rst_q) begin
			// Buffers are not touched here, so an aborted program can be reissued
			n.phase = PH_OP;
			n.busy  = 1'b0;
			n.cnt   = 7'h00;
			n.so_oe = 1'b0;
		end else begin
			if (op_done && r.busy) begin
				n.busy = 1'b0;
				if (r.op_code == sflash_pkg::OP_CMP1 || r.op_code == sflash_pkg::OP_CMP2) begin
					n.cmp = op_mismatch;
				end
			end
			if (cs_q) begin
				// Launch only for a complete header; reads of the idle buffer stay allowed
				if (cs_rise && r.phase == PH_DATA && sflash_pkg::is_launch(r.op) && !r.busy) begin
					n.op_valid = 1'b1;
					n.op_code  = r.op;
					n.op_page  = r.adr[sflash_pkg::PAGE_LSB +: 11];
					n.busy     = 1'b1;
				end
				n.phase = PH_OP;
				n.cnt   = 7'h00;
				n.so_oe = 1'b0;
			end else begin
				if (sck_rise) begin
					n.ish = ish_n;
					n.cnt = r.cnt + 7'h01;
					case (r.phase)
						PH_OP: begin
							if (r.cnt == 7'h07) begin
								n.op  = ish_n;
								n.cnt = 7'h00;
								n.bcnt = 3'h0;
								if (ish_n == sflash_pkg::OP_STATUS) begin
									n.phase = PH_DATA;
								end else if (sflash_pkg::is_valid(ish_n)) begin
									n.phase = PH_HDR;
								end else begin
									n.phase = PH_BAD;
								end
							end
						end
						PH_HDR: begin
							if (r.cnt < 7'(sflash_pkg::ADDR_BITS)) begin
								n.adr = adr_n;
							end
							if (r.cnt == 7'(hdr_bits(r.op) - 1)) begin
								n.phase = PH_DATA;
								n.bcnt  = 3'h0;
								n.ptr   = (r.cnt < 7'(sflash_pkg::ADDR_BITS)) ? adr_n[8:0]
									: r.adr[8:0];
							end
						end
						PH_DATA: begin
							if (sflash_pkg::is_write(r.op)) begin
								n.bcnt = r.bcnt + 3'h1;
								if (r.bcnt == 3'h7) begin
									wr_en = 1'b1;
									n.ptr = next_ptr(r.ptr);
								end
							end
						end
						default: begin
							n.phase = PH_BAD;
						end
					endcase
				end
				if (sck_fall && r.phase == PH_DATA && sflash_pkg::is_read(r.op)) begin
					n.so_oe = 1'b1;
					n.bcnt  = r.bcnt + 3'h1;
					if (r.bcnt == 3'h0) begin
						if (r.op == sflash_pkg::OP_STATUS) begin
							src = {r.rdy, r.cmp, sflash_pkg::DENSITY_CODE,
								sflash_pkg::STAT_RSVD};
						end else if (r.op == sflash_pkg::OP_PAGE_RD) begin
							src   = arr_rdata;
							n.ptr = next_ptr(r.ptr);
						end else begin
							src   = use_buf2(r.op) ? buf2[r.ptr] : buf1[r.ptr];
							n.ptr = next_ptr(r.ptr);
						end
						n.so  = src[7];
						n.osh = {src[6:0], 1'b0};
					end else begin
						n.so  = r.osh[7];
						n.osh = {r.osh[6:0], 1'b0};
					end
				end
			end
		end
		n.rdy = !n.busy;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '{phase: PH_OP, rdy: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	// Buffers carry no reset so that neither reset disturbs their contents
	always_ff @(posedge hclk) begin
		if (wr_en && !wr_b2) begin
			buf1[wr_adr] <= wr_dat;
		end
		if (wr_en && wr_b2) begin
			buf2[wr_adr] <= wr_dat;
		end
	end

	assign link.so    = r.so;
	assign link.so_oe = r.so_oe;
	assign link.rdy   = r.rdy;
	assign op_valid   = r.op_valid;
	assign op_code    = r.op_code;
	assign op_page    = r.op_page;
	assign arr_byte   = r.ptr;
endmodule

// ===== hdl/flash_host.sv
// Host end: AHB-Lite register slave driving the serial flash link bytewise
`timescale 1ns/1ns
module flash_host (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	sflash_if.host           link
);
	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} hstate_t;

	typedef struct packed {
		hstate_t     st;
		logic [2:0]  cnt;
		logic [2:0]  bits;
		logic [7:0]  tx;
		logic [7:0]  rx;
		logic [8:0]  cmd;
		logic        mode3;
		logic        frst;
		logic        rst_n;
		logic        sck;
		logic        cs_n;
		logic        si;
		logic        wr_pend;
		logic [11:0] wr_adr;
		logic [31:0] hrdata;
	} state_t;

	state_t r;
	state_t n;
	logic   so_q;
	logic   rdy_q;

	pin_sync u_so (.hclk(hclk), .hresetn(hresetn), .d(link.so_line),
		.q(so_q), .rise(), .fall());
	pin_sync u_rdy (.hclk(hclk), .hresetn(hresetn), .d(link.rdy),
		.q(rdy_q), .rise(), .fall());

	always_comb begin
		logic        busy;
		logic [11:0] a;
		n    = r;
		busy = (r.st != H_IDLE);
		a    = haddr[11:0];
		n.wr_pend = 1'b0;
		if (hsel && htrans[1] && hready) begin
			n.wr_pend = hwrite;
			n.wr_adr  = a;
			n.hrdata  = 32'h0000_0000;
			if (a == sflash_pkg::REG_CMD) begin
				n.hrdata = {23'h000000, r.cmd};
			end else if (a == sflash_pkg::REG_STAT) begin
				n.hrdata = {16'h0000, r.rx, 6'h00, rdy_q, busy};
			end else if (a == sflash_pkg::REG_CFG) begin
				n.hrdata = {30'h00000000, r.frst, r.mode3};
			end
		end
		if (r.wr_pend && r.wr_adr == sflash_pkg::REG_CFG) begin
			n.mode3 = hwdata[sflash_pkg::CFG_MODE3_BIT];
			n.frst  = hwdata[sflash_pkg::CFG_RST_BIT];
			n.rst_n = !hwdata[sflash_pkg::CFG_RST_BIT];
		end
		n.cnt = r.cnt + 3'h1;
		case (r.st)
			H_IDLE: begin
				if (r.cs_n) begin
					n.sck = r.mode3;
				end
				if (r.wr_pend && r.wr_adr == sflash_pkg::REG_CMD) begin
					// Commands written while a byte is moving are dropped
					n.cmd = hwdata[8:0];
					n.tx  = hwdata[7:0];
					n.cnt = 3'h0;
					n.st  = r.cs_n ? H_SETUP : H_LOW;
					n.cs_n = 1'b0;
					if (!r.cs_n) begin
						n.sck = 1'b0;
						n.si  = hwdata[7];
					end
				end
			end
			H_SETUP: begin
				if (r.cnt == 3'(sflash_pkg::SCK_HALF_CYC - 1)) begin
					n.st  = H_LOW;
					n.cnt = 3'h0;
					n.sck = 1'b0;
					n.si  = r.tx[7];
				end
			end
			H_LOW: begin
				if (r.cnt == 3'(sflash_pkg::SCK_HALF_CYC - 1)) begin
					n.st  = H_HIGH;
					n.cnt = 3'h0;
					n.sck = 1'b1;
				end
			end
			H_HIGH: begin
				// Sampled late in the high half: the device answers a few cycles after the fall
				if (r.cnt == 3'(sflash_pkg::SAMPLE_CYC)) begin
					n.rx = {r.rx[6:0], so_q};
				end
				if (r.cnt == 3'(sflash_pkg::SCK_HALF_CYC - 1)) begin
					n.cnt = 3'h0;
					if (r.bits == 3'h7) begin
						n.bits = 3'h0;
						n.sck  = r.mode3;
						n.st   = r.cmd[sflash_pkg::CMD_HOLD_BIT] ? H_IDLE : H_END;
					end else begin
						n.bits = r.bits + 3'h1;
						n.tx   = {r.tx[6:0], 1'b0};
						n.si   = r.tx[6];
						n.sck  = 1'b0;
						n.st   = H_LOW;
					end
				end
			end
			default: begin
				if (r.cnt == 3'(sflash_pkg::SCK_HALF_CYC - 1)) begin
					n.cs_n = 1'b1;
					n.st   = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '{st: H_IDLE, cs_n: 1'b1, si: 1'b1, rst_n: 1'b1, default: '0};
		end else begin
			r <= n;
		end
	end

	assign hrdata         = r.hrdata;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign link.sck       = r.sck;
	assign link.cs_n      = r.cs_n;
	assign link.si        = r.si;
	assign link.rst_pin_n = r.rst_n;
endmodule

// ===== hdl/pin_sync.sv
// Two-flop synchroniser with edge pulses taken after the second flop
`timescale 1ns/1ns
module pin_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic d,
	output logic      q,
	output logic      rise,
	output logic      fall
);
	logic [2:0] s_r;

	// Reset level matches the pin's idle level, so no false edge follows reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_r <= {3{RST_VAL}};
		end else begin
			s_r <= {s_r[1:0], d};
		end
	end

	assign q    = s_r[1];
	assign rise = s_r[1] & ~s_r[2];
	assign fall = ~s_r[1] & s_r[2];
endmodule

// ===== verif/flash_link_monitor_monitor.sv
// Checker on the serial link between the host end and the device end
`timescale 1ns/1ns
module flash_link_monitor (
	input  wire logic hclk,
	input  wire logic hresetn,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	input  wire logic so,
	input  wire logic so_oe,
	input  wire logic rdy,
	input  wire logic rst_pin_n
);
	typedef struct packed {
		logic       sck_q;
		logic [2:0] fall_age;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] op;
		logic       opv;
	} mon_t;
	mon_t mon_r;
	mon_t mon_nxt;

	// Counts cycles since the raw clock fell, saturating so it never wraps to a false match
	always_comb begin
		mon_nxt = mon_r;
		mon_nxt.sck_q = sck;
		if (mon_r.sck_q && !sck) begin
			mon_nxt.fall_age = 3'h0;
		end else if (mon_r.fall_age != 3'h7) begin
			mon_nxt.fall_age = mon_r.fall_age + 3'h1;
		end
		if (cs_n) begin
			mon_nxt.cnt = 3'h0;
			mon_nxt.opv = 1'b0;
		end else if (!mon_r.sck_q && sck) begin
			mon_nxt.sh = {mon_r.sh[6:0], si};
			mon_nxt.cnt = mon_r.cnt + 3'h1;
			if (mon_r.cnt == 3'h7 && !mon_r.opv) begin
				mon_nxt.op = {mon_r.sh[6:0], si};
				mon_nxt.opv = 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mon_r <= '0;
		end else begin
			mon_r <= mon_nxt;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence frame_idle;
		cs_n [*6];
	endsequence
	sequence link_held_reset;
		!rst_pin_n [*5];
	endsequence
	sequence status_start;
		$rose(so_oe) && mon_r.opv && mon_r.op == sflash_pkg::OP_STATUS;
	endsequence

	a_idle_so_float: assert property (frame_idle |-> !so_oe)
		else $error("output driven while deselected");
	a_reset_oe_off: assert property (link_held_reset |-> !so_oe)
		else $error("output driven during link reset");
	a_reset_ready: assert property (link_held_reset |-> rdy)
		else $error("busy shown during link reset");
	a_so_edge_fall: assert property ((so_oe && $past(so_oe) && $changed(so))
		|-> mon_r.fall_age <= 3'h5) else $error("output bit changed away from falling edge");
	a_oe_start_fall: assert property ($rose(so_oe) |-> !cs_n && mon_r.fall_age <= 3'h5)
		else $error("output started away from falling edge");
	a_rdy_after_cs: assert property ($fell(rdy) |-> cs_n)
		else $error("busy began inside a frame");
	a_status_ready_bit: assert property (status_start |-> so == rdy)
		else $error("first status bit differs from ready pin");
	a_oe_reads_only: assert property ($rose(so_oe)
		|-> mon_r.opv && mon_r.op inside {8'h52, 8'h54, 8'h56, 8'h57})
		else $error("output driven for a command without read data");
endmodule

// ===== verif/serial_page_flash_command_front_end_tb.sv
// Self-checking bench joining the host end and the device end over the serial link
`timescale 1ns/1ns
module serial_page_flash_command_front_end_tb;
	localparam logic [7:0] LAUNCH_OPS [12] = '{8'h53, 8'h55, 8'h60, 8'h61, 8'h83, 8'h86,
		8'h88, 8'h89, 8'h82, 8'h85, 8'h58, 8'h59};
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        op_done;
	logic        op_mismatch;
	logic [7:0]  arr_rdata;
	logic        op_valid;
	logic [7:0]  op_code;
	logic [10:0] op_page;
	logic [8:0]  arr_byte;
	int          bad_count;
	int          cmp_count;
	integer      seed;
	int          buf_mdl [2][264];
	logic        cmp_mdl;
	logic [18:0] op_q [$];
	logic [31:0] rd;
	logic [7:0]  rx;
	logic [7:0]  d0;
	logic [7:0]  d1;
	logic [10:0] pg;
	logic        mm;

	sflash_if lnk ();
	flash_host u_flash_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(lnk));
	flash_front_end u_flash_front_end (.hclk(hclk), .hresetn(hresetn), .link(lnk),
		.op_done(op_done), .op_mismatch(op_mismatch), .arr_rdata(arr_rdata),
		.op_valid(op_valid), .op_code(op_code), .op_page(op_page), .arr_byte(arr_byte));
	flash_link_monitor u_flash_link_monitor (.hclk(hclk), .hresetn(hresetn), .sck(lnk.sck),
		.cs_n(lnk.cs_n), .si(lnk.si), .so(lnk.so), .so_oe(lnk.so_oe), .rdy(lnk.rdy),
		.rst_pin_n(lnk.rst_pin_n));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	// Array side answers one cycle late, inside the allowed settling time
	always @(posedge hclk) begin
		arr_rdata <= arr_byte[7:0] ^ 8'hA5;
		if (op_valid === 1'b1) begin
			op_q.push_back({op_code, op_page});
		end
	end

	task automatic report_and_stop();
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_op(input logic [18:0] exp);
		logic [18:0] got;
		got = 'x;
		for (int i = 0; i < 40 && op_q.size() == 0; i++) @(posedge hclk);
		if (op_q.size() > 0) begin
			got = op_q.pop_front();
		end
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD launch expected %h seen %h", exp, got);
		end
	endtask

	// Single word transfer; waits on ready rather than assuming the slave's latency
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {20'h0, a};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic xfer(input logic [7:0] b, input logic keep);
		ahb(1'b1, sflash_pkg::REG_CMD, {23'h0, keep, b});
		do ahb(1'b0, sflash_pkg::REG_STAT, 32'h0); while (rd[0] !== 1'b0);
		rx = rd[15:8];
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic keep);
		xfer(op, 1'b1);
		xfer(a[23:16], 1'b1);
		xfer(a[15:8], 1'b1);
		xfer(a[7:0], keep);
	endtask

	task automatic status_check(input logic busy);
		logic [7:0] exp;
		exp = {~busy, cmp_mdl, sflash_pkg::DENSITY_CODE, sflash_pkg::STAT_RSVD};
		xfer(sflash_pkg::OP_STATUS, 1'b1);
		xfer(8'hFF, 1'b1);
		check8("status first", exp, rx);
		xfer(8'hFF, 1'b0);
		check8("status repeat", exp, rx);
		check8("ready pin", {7'h0, ~busy}, {7'h0, rd[1]});
	endtask

	initial begin
		repeat (80000) @(posedge hclk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		seed = 32'h5c2d;
		bad_count = 0;
		cmp_count = 0;
		cmp_mdl = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		op_done = 1'b0;
		op_mismatch = 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		status_check(1'b0);
		ahb(1'b1, sflash_pkg::REG_CFG, 32'h1);
		status_check(1'b0);
		ahb(1'b1, sflash_pkg::REG_CFG, 32'h0);
		for (int k = 0; k < 2; k++) begin
			d0 = 8'($random(seed));
			d1 = 8'($random(seed));
			cmd(k ? sflash_pkg::OP_BUF2_WR : sflash_pkg::OP_BUF1_WR,
				{15'h0, sflash_pkg::PAGE_LAST}, 1'b1);
			xfer(d0, 1'b1);
			xfer(d1, 1'b0);
			buf_mdl[k][263] = d0;
			buf_mdl[k][0] = d1;
		end
		foreach (LAUNCH_OPS[i]) begin
			pg = 11'($random(seed));
			mm = 1'($random(seed));
			cmd(LAUNCH_OPS[i], {4'h0, pg, 9'($random(seed))}, 1'b0);
			check_op({LAUNCH_OPS[i], pg});
			status_check(1'b1);
			@(posedge hclk);
			op_done <= 1'b1;
			op_mismatch <= mm;
			@(posedge hclk);
			op_done <= 1'b0;
			if (LAUNCH_OPS[i] inside {8'h60, 8'h61}) begin
				cmp_mdl = mm;
			end
			status_check(1'b0);
		end
		check8("stray launches", 8'h00, 8'(op_q.size()));
		cmd(8'h00, 24'($random(seed)), 1'b1);
		xfer(8'h00, 1'b0);
		check8("invalid output", 8'hFF, rx);
		repeat (20) @(posedge hclk);
		check8("invalid launches", 8'h00, 8'(op_q.size()));
		// Link reset in mid program must abort it yet keep both buffers
		cmd(sflash_pkg::OP_PGM_ER1, {4'h0, pg, 9'h0}, 1'b0);
		check_op({sflash_pkg::OP_PGM_ER1, pg});
		ahb(1'b1, sflash_pkg::REG_CFG, 32'h2);
		repeat (8) @(posedge hclk);
		ahb(1'b1, sflash_pkg::REG_CFG, 32'h0);
		repeat (8) @(posedge hclk);
		ahb(1'b0, sflash_pkg::REG_STAT, 32'h0);
		check8("ready after reset", 8'h01, {7'h0, rd[1]});
		for (int k = 0; k < 2; k++) begin
			cmd(k ? sflash_pkg::OP_BUF2_RD : sflash_pkg::OP_BUF1_RD,
				{15'h0, sflash_pkg::PAGE_LAST}, 1'b1);
			xfer(8'hFF, 1'b1);
			xfer(8'hFF, 1'b1);
			check8("buffer end", 8'(buf_mdl[k][263]), rx);
			xfer(8'hFF, 1'b0);
			check8("buffer wrap", 8'(buf_mdl[k][0]), rx);
		end
		cmd(sflash_pkg::OP_PAGE_RD, {4'h0, pg, sflash_pkg::PAGE_LAST}, 1'b1);
		repeat (5) xfer(8'hFF, 1'b1);
		check8("page end", 8'(sflash_pkg::PAGE_LAST) ^ 8'hA5, rx);
		xfer(8'hFF, 1'b0);
		check8("page wrap", 8'hA5, rx);
		check8("bus response", 8'h00, {7'h0, hresp});
		report_and_stop();
	end
endmodule
